// *** src/lpd_pkg.sv ***
// Package for the LED driver power-up default register bank
package lpd_pkg;

  localparam int NREG = 18;

  // Register offsets, in table order
  localparam logic [7:0] OFF_STRING_ENABLE_LOW       = 8'h00;
  localparam logic [7:0] OFF_STRING_ENABLE_HIGH      = 8'h01;
  localparam logic [7:0] OFF_GENERAL_CONFIGURATION   = 8'h02;
  localparam logic [7:0] OFF_GLOBAL_FAULT_ENABLE     = 8'h03;
  localparam logic [7:0] OFF_STRING_FAULT_ENABLE_LOW = 8'h04;
  localparam logic [7:0] OFF_STRING_FAULT_ENABLE_HI  = 8'h05;
  localparam logic [7:0] OFF_OSCILLATOR_FREQUENCY    = 8'h0F;
  localparam logic [7:0] OFF_OPTIMIZER_CONTROL_A     = 8'h10;
  localparam logic [7:0] OFF_OPTIMIZER_CONTROL_B     = 8'h11;
  localparam logic [7:0] OFF_OPTIMIZER_CONTROL_C     = 8'h12;
  localparam logic [7:0] OFF_GRAYSCALE_CLOCK_CONTROL = 8'h20;
  localparam logic [7:0] OFF_GEN_COUNT_LOW           = 8'h21;
  localparam logic [7:0] OFF_GEN_COUNT_HIGH          = 8'h22;
  localparam logic [7:0] OFF_GRAYSCALE_MULTIPLIER    = 8'h23;
  localparam logic [7:0] OFF_GRAYSCALE_DIVIDER       = 8'h24;
  localparam logic [7:0] OFF_MAX_COUNT_LOW           = 8'h25;
  localparam logic [7:0] OFF_MAX_COUNT_HIGH          = 8'h26;
  localparam logic [7:0] OFF_FRAME_SYNC_CONTROL      = 8'h27;

  localparam logic [7:0] REG_OFFS [NREG] = '{
    OFF_STRING_ENABLE_LOW, OFF_STRING_ENABLE_HIGH, OFF_GENERAL_CONFIGURATION,
    OFF_GLOBAL_FAULT_ENABLE, OFF_STRING_FAULT_ENABLE_LOW, OFF_STRING_FAULT_ENABLE_HI,
    OFF_OSCILLATOR_FREQUENCY, OFF_OPTIMIZER_CONTROL_A, OFF_OPTIMIZER_CONTROL_B,
    OFF_OPTIMIZER_CONTROL_C, OFF_GRAYSCALE_CLOCK_CONTROL, OFF_GEN_COUNT_LOW,
    OFF_GEN_COUNT_HIGH, OFF_GRAYSCALE_MULTIPLIER, OFF_GRAYSCALE_DIVIDER,
    OFF_MAX_COUNT_LOW, OFF_MAX_COUNT_HIGH, OFF_FRAME_SYNC_CONTROL};

  // Power-up contents, held until the nonvolatile copy arrives
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h55, 8'h5A, 8'h0D, 8'h27, 8'h55, 8'h5A, 8'h04, 8'h49, 8'h1A,
    8'h03, 8'h00, 8'h50, 8'h00, 8'h03, 8'h00, 8'hAE, 8'h00, 8'h00};

  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Load sequencer states
  typedef enum logic [1:0]
  {
    LPD_REQ  = 2'b00,
    LPD_CAP  = 2'b01,
    LPD_RUN  = 2'b10
  } lpd_state_e;

  // Decoded configuration handed to the rest of the chip
  typedef struct packed
  {
    logic [15:0] string_enable;
    logic [7:0]  general_configuration;
    logic [7:0]  global_fault_enable;
    logic [15:0] string_fault_enable;
    logic [7:0]  oscillator_frequency;
    logic [7:0]  optimizer_control_a;
    logic [7:0]  optimizer_control_b;
    logic [7:0]  optimizer_control_c;
    logic [7:0]  grayscale_clock_control;
    logic [15:0] grayscale_generator_count;
    logic [7:0]  grayscale_multiplier;
    logic [7:0]  grayscale_divider;
    logic [15:0] grayscale_max_count;
    logic [7:0]  frame_sync_control;
  } lpd_cfg_s;

endpackage

// *** src/lpd_regbank.sv ***
// Configuration register bank with nonvolatile power-up load
`timescale 1ns/1ps

// Overview of operation
// - After reset, every listed register is reloaded from nonvolatile memory.
// - String enables default to 0x55 and 0x5A.
// - General configuration defaults to 0x0D.
// - Global fault enable defaults to 0x27.
// - Per-string fault enables default to 0x55 and 0x5A.
// - Oscillator frequency code defaults to 0x04.
// - First optimizer control defaults to 0x49.
// - Second optimizer control defaults to 0x1A.
// - Third optimizer control defaults to 0x03.
// - Grayscale clock control defaults to 0x00.
// - Generator ticks at clock divided by count plus one; count defaults 80.
// - Grayscale multiplier defaults to 0x03, factor four.
// - Grayscale divider defaults to 0x00, divide by one.
// - Grayscale max count defaults to 0x00AE.
// - Frame-sync control defaults to 0x00.
module lpd_regbank
  import lpd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_q,
  output logic            nvm_rd_q,
  output logic      [7:0] nvm_addr_q,
  input  wire logic [7:0] nvm_data,
  output logic            load_done_q,
  output lpd_cfg_s        cfg_q,
  output logic            gsc_tick_q
);

  // ------------------------------------------------------------
  // Storage and address decode
  // ------------------------------------------------------------
  logic [7:0]      regs_q [NREG];
  logic [NREG-1:0] hit;
  logic [4:0]      idx_q;
  logic [4:0]      idx_d;
  lpd_state_e      st_q;
  lpd_state_e      st_d;
  logic [7:0]      rd_mux;
  logic            mapped;
  logic            cap_now;
  logic            host_wr;

  // Host writes are refused while the load runs, so it cannot be overwritten
  // Dropping rather than queueing keeps the loader free of any backpressure
  assign cap_now = ce && (st_q == LPD_CAP);
  assign host_wr = ce && reg_wr && (st_q == LPD_RUN);
  assign mapped  = |hit;

  // One decoder and one byte register per entry
  // Reset fills the defaults so the bank is sane before the first byte arrives
  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_reg
      assign hit[g] = (reg_addr == REG_OFFS[g]);

      always_ff @(posedge clk)
      begin
        if (sys_rst)
          regs_q[g] <= REG_RST[g];
        else if (cap_now && idx_q == 5'(g))
          regs_q[g] <= nvm_data;
        else if (host_wr && hit[g])
          regs_q[g] <= reg_wdata;
      end
    end
  endgenerate

  // Read multiplexer; unmapped offsets read as zero
  // Priority does not matter: offsets are unique, so at most one hit is set
  always_comb
  begin
    rd_mux = RD_UNMAPPED;
    for (int i = 0; i < NREG; i++)
    begin
      if (hit[i])
        rd_mux = regs_q[i];
    end
  end

  // Read data is registered; it holds until the next accepted read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata_q <= RD_UNMAPPED;
    else if (ce && reg_rd)
      reg_rdata_q <= mapped ? rd_mux : RD_UNMAPPED;
  end

  // ------------------------------------------------------------
  // Nonvolatile load sequencer
  // ------------------------------------------------------------
  // The strobe rises as the sequencer enters the capture state and the byte
  // is taken at the edge that ends that cycle, so the memory must answer
  // within the strobe cycle. One request every two enabled cycles keeps the
  // address stable for a whole cycle before each capture.
  always_comb
  begin
    st_d  = st_q;
    idx_d = idx_q;
    case (st_q)
      LPD_REQ:
        st_d = LPD_CAP;
      LPD_CAP:
      begin
        if (idx_q == 5'(NREG - 1))
          st_d = LPD_RUN;
        else
        begin
          st_d  = LPD_REQ;
          idx_d = idx_q + 5'd1;
        end
      end
      LPD_RUN:
        st_d = LPD_RUN;
      default:
        st_d = LPD_REQ;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q        <= LPD_REQ;
      idx_q       <= 5'd0;
      nvm_rd_q    <= 1'b0;
      nvm_addr_q  <= 8'h00;
      load_done_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q        <= st_d;
      idx_q       <= idx_d;
      nvm_rd_q    <= (st_d == LPD_CAP);
      nvm_addr_q  <= REG_OFFS[idx_d];
      load_done_q <= (st_d == LPD_RUN);
    end
  end

  // ------------------------------------------------------------
  // Configuration outputs
  // ------------------------------------------------------------
  lpd_cfg_s cfg_d;

  assign cfg_d.string_enable             = {regs_q[1], regs_q[0]};
  assign cfg_d.general_configuration     = regs_q[2];
  assign cfg_d.global_fault_enable       = regs_q[3];
  assign cfg_d.string_fault_enable       = {regs_q[5], regs_q[4]};
  assign cfg_d.oscillator_frequency      = regs_q[6];
  assign cfg_d.optimizer_control_a       = regs_q[7];
  assign cfg_d.optimizer_control_b       = regs_q[8];
  assign cfg_d.optimizer_control_c       = regs_q[9];
  assign cfg_d.grayscale_clock_control   = regs_q[10];
  assign cfg_d.grayscale_generator_count = {regs_q[12], regs_q[11]};
  assign cfg_d.grayscale_multiplier      = regs_q[13];
  assign cfg_d.grayscale_divider         = regs_q[14];
  assign cfg_d.grayscale_max_count       = {regs_q[16], regs_q[15]};
  assign cfg_d.frame_sync_control        = regs_q[17];

  // One cycle behind the storage so the port comes from a flop
  // The extra cycle of latency is traded for clean timing into the rest of the chip
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cfg_q <= '0;
    else if (ce)
      cfg_q <= cfg_d;
  end

  // ------------------------------------------------------------
  // Internal grayscale clock generator
  // ------------------------------------------------------------
  logic [15:0] gen_cnt_q;
  logic        gen_wrap;

  // A count of zero gives a tick every enabled cycle
  // Greater-or-equal rather than equal, so lowering the count mid-period
  // wraps at once instead of running the full sixteen-bit range
  assign gen_wrap = (gen_cnt_q >= cfg_q.grayscale_generator_count);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      gen_cnt_q  <= 16'h0000;
      gsc_tick_q <= 1'b0;
    end
    else if (ce)
    begin
      gen_cnt_q  <= gen_wrap ? 16'h0000 : gen_cnt_q + 16'h0001;
      gsc_tick_q <= gen_wrap;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  nvm_strobe_short_a: assert property (nvm_rd_q && ce |=> !nvm_rd_q)
    else $error("nonvolatile read strobe held too long");
  nvm_capture_a: assert property (
    cap_now && idx_q == 5'd2 |=> regs_q[2] == $past(nvm_data))
    else $error("loaded byte not stored");
  strings_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[0] == 8'h55 && regs_q[1] == 8'h5A)
    else $error("string enable default wrong");
  config_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[2] == 8'h0D && regs_q[3] == 8'h27 && regs_q[6] == 8'h04)
    else $error("configuration default wrong");
  fault_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[4] == 8'h55 && regs_q[5] == 8'h5A)
    else $error("string fault enable default wrong");
  optimizer_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[7] == 8'h49 && regs_q[8] == 8'h1A && regs_q[9] == 8'h03)
    else $error("optimizer default wrong");
  gsc_default_a: assert property (disable iff (1'b0)
    sys_rst |=> {regs_q[12], regs_q[11]} == 16'h0050 && regs_q[13] == 8'h03
             && regs_q[14] == 8'h00 && {regs_q[16], regs_q[15]} == 16'h00AE
             && regs_q[10] == 8'h00 && regs_q[17] == 8'h00)
    else $error("grayscale default wrong");
  host_write_a: assert property (
    host_wr && reg_addr == 8'h02 ##1 ce |=> cfg_q.general_configuration
      == $past(reg_wdata, 2))
    else $error("host write not visible");
  load_hold_a: assert property (
    load_done_q && !(ce && reg_wr) |=> $stable(regs_q[3]))
    else $error("register changed without a write");
  tick_period_a: assert property (
    ce && gsc_tick_q && cfg_q.grayscale_generator_count != 16'h0000
      && $stable(cfg_q) |=> !gsc_tick_q)
    else $error("generator ticked early");

  gen_reset_a: assert property (gsc_tick_q |-> gen_cnt_q == 16'h0000)
    else $error("generator did not restart after a tick");
  gen_bound_a: assert property (
    ce && !gen_wrap |=> gen_cnt_q != 16'h0000)
    else $error("generator restarted without a wrap");

  // ------------------------------------------------------------
  // Default checks per register
  // ------------------------------------------------------------
  // One check per rule except string and fault enables, general config, optimizer A and generator count, so a failure names the register
  // Reset is the event under test here, so these ignore the default disable
  global_fault_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[3] == 8'h27)
    else $error("global fault enable default wrong");
  osc_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[6] == 8'h04)
    else $error("oscillator default wrong");
  ctrl_b_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[8] == 8'h1A)
    else $error("second optimizer default wrong");
  ctrl_c_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[9] == 8'h03)
    else $error("third optimizer default wrong");
  gsc_ctrl_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[10] == 8'h00)
    else $error("grayscale clock control default wrong");
  multiplier_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[13] == 8'h03)
    else $error("multiplier default wrong");
  divider_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[14] == 8'h00)
    else $error("divider default wrong");
  max_count_default_a: assert property (disable iff (1'b0)
    sys_rst |=> {regs_q[16], regs_q[15]} == 16'h00AE)
    else $error("max count default wrong");
  frame_sync_default_a: assert property (disable iff (1'b0)
    sys_rst |=> regs_q[17] == 8'h00)
    else $error("frame sync control default wrong");

  // ------------------------------------------------------------
  // Load sequencer checks
  // ------------------------------------------------------------
  // The loader must walk the offsets in table order and stop for good
  load_order_a: assert property (nvm_rd_q |-> nvm_addr_q == REG_OFFS[idx_q])
    else $error("nonvolatile address out of order");
  idx_range_a: assert property (idx_q <= 5'(NREG - 1))
    else $error("load index past the last register");
  load_done_hold_a: assert property (load_done_q |=> load_done_q)
    else $error("load done dropped");
  load_end_a: assert property (load_done_q |-> !nvm_rd_q)
    else $error("nonvolatile read after the load");
  load_refuse_a: assert property (
    ce && reg_wr && !load_done_q && reg_addr == 8'h02
      && !(cap_now && idx_q == 5'd2) |=> $stable(regs_q[2]))
    else $error("host write taken during the load");
  freeze_a: assert property (
    !ce |=> $stable(st_q) && $stable(cfg_q) && $stable(gen_cnt_q)
      && $stable(regs_q[2]))
    else $error("state moved while the clock enable was low");
  rst_outputs_a: assert property (disable iff (1'b0)
    sys_rst |=> !nvm_rd_q && !load_done_q && !gsc_tick_q && reg_rdata_q == 8'h00)
    else $error("outputs not cleared by reset");

  // ------------------------------------------------------------
  // Host port checks
  // ------------------------------------------------------------
  // Reads answer one cycle later and hold; writes land in storage next edge
  read_data_a: assert property (
    ce && reg_rd && reg_addr == 8'h02 |=> reg_rdata_q == $past(regs_q[2]))
    else $error("read data does not match storage");
  unmapped_read_a: assert property (
    ce && reg_rd && !mapped |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    !(ce && reg_rd) |=> $stable(reg_rdata_q))
    else $error("read data changed without a read");
  host_store_a: assert property (
    host_wr && reg_addr == 8'h03 |=> regs_q[3] == $past(reg_wdata))
    else $error("host write not stored");
  cfg_follow_a: assert property (
    ce |=> cfg_q == $past(cfg_d))
    else $error("configuration port lags storage");

  // ------------------------------------------------------------
  // Cover points
  // ------------------------------------------------------------

  load_done_c: cover property ($rose(load_done_q));
  host_wr_c:   cover property (host_wr && mapped);
  tick_c:      cover property (gsc_tick_q);
  unmapped_c:  cover property (ce && reg_rd && !mapped);
  refused_c:   cover property (ce && reg_wr && !load_done_q);

endmodule

// *** verification/lpd_nvm_model.sv ***
// Nonvolatile memory model that answers the power-up load
`timescale 1ns/1ps
module lpd_nvm_model
  import lpd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       ce,
  input  wire logic       rd,
  input  wire logic [7:0] addr,
  input  wire logic       flip,
  output logic      [7:0] data
);
  logic [7:0] val;
  // ----------------------------------------
  // Stored image and answer timing
  // ----------------------------------------
  // Image holds the register defaults; flip selects a second image
  always_comb
  begin
    val = 8'h00;
    for (int i = 0; i < NREG; i++)
      if (REG_OFFS[i] == addr)
        val = REG_RST[i] ^ (flip ? 8'h3C : 8'h00);
  end
  // The loader takes the byte at the edge that ends its strobe cycle, so the
  // answer is combinational; outside a strobe the port shows junk on purpose
  assign data = (ce && rd) ? val : ~val;
endmodule

// *** verification/lpd_regbank_tb_top.sv ***
// Self-checking testbench for the power-up default register bank
`timescale 1ns/1ps
module lpd_regbank_tb_top
  import lpd_pkg::*;
;
  localparam logic [7:0] EXP [NREG] = '{8'h55, 8'h5A, 8'h0D, 8'h27, 8'h55, 8'h5A, 8'h04,
    8'h49, 8'h1A, 8'h03, 8'h00, 8'h50, 8'h00, 8'h03, 8'h00, 8'hAE, 8'h00, 8'h00};
  logic       clk, sys_rst, ce, reg_wr, reg_rd, flip, nvm_rd_q, load_done_q, gsc_tick_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, nvm_addr_q, nvm_data;
  lpd_cfg_s   cfg_q;
  int         n_fail, compares, n;
  // ----------------------------------------
  // Design, memory model and clock
  // ----------------------------------------
  lpd_regbank u_dut (.clk, .sys_rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_q, .nvm_rd_q, .nvm_addr_q, .nvm_data, .load_done_q, .cfg_q, .gsc_tick_q);
  lpd_nvm_model u_nvm (.clk, .ce, .rd(nvm_rd_q), .addr(nvm_addr_q), .flip, .data(nvm_data));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task reset;
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
  endtask
  // Strobes rise and fall on falling edges, so each is taken at exactly one rising edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    check($sformatf("rdata at %h", a), {8'h00, reg_rdata_q}, {8'h00, exp});
  endtask
  // Bounded wait on a flag; running out counts as a failure and ends the run
  task wait_hi(input int which);
    n = 0;
    while ((which ? gsc_tick_q : load_done_q) !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
    begin
      n_fail++;
      test_done();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {sys_rst, ce, reg_wr, reg_rd, flip} = 5'b11001;
    {reg_addr, reg_wdata, n_fail, compares} = '0;
    reset();
    wr(OFF_GENERAL_CONFIGURATION, 8'hFF);
    wait_hi(0);
    // Second image proves the contents come from memory; the early write was dropped
    for (int i = 0; i < NREG; i++)
      rd(REG_OFFS[i], EXP[i] ^ 8'h3C);
    flip = 1'b0;
    reset();
    wait_hi(0);
    for (int i = 0; i < NREG; i++)
      rd(REG_OFFS[i], EXP[i]);
    check("string_enable", cfg_q.string_enable, 16'h5A55);
    check("string_fault_enable", cfg_q.string_fault_enable, 16'h5A55);
    check("gen_count", cfg_q.grayscale_generator_count, 16'h0050);
    check("max_count", cfg_q.grayscale_max_count, 16'h00AE);
    rd(8'h06, 8'h00);
    wr(8'h30, 8'h77);
    rd(8'h30, 8'h00);
    wr(OFF_GENERAL_CONFIGURATION, 8'hA5);
    rd(OFF_GENERAL_CONFIGURATION, 8'hA5);
    check("general_cfg", {8'h00, cfg_q.general_configuration}, 16'h00A5);
    rd(OFF_GLOBAL_FAULT_ENABLE, 8'h27);
    // Short generator count keeps the tick period measurable
    wr(OFF_GEN_COUNT_LOW, 8'h03);
    repeat (6) @(negedge clk);
    wait_hi(1);
    @(negedge clk);
    wait_hi(1);
    check("tick period", n[15:0] + 16'h0001, 16'h0004);
    test_done();
  end
endmodule
